//--- src/rcfg_guard.sv
// guard interval timer: ignores receiver input after each transmission
// assumes start and half_bit_tick are one-cycle pulses on aclk
`timescale 1ns/1ps
module rcfg_guard (
   input  wire logic  aclk,
   input  wire logic  aresetn,
   input  wire logic  half_bit_tick,
   rcfg_guard_if.timer gi
);

   rcfg_pkg::rcfg_guard_state_type state;
   rcfg_pkg::rcfg_guard_state_type next_state;
   logic [6:0] remain;
   logic [6:0] next_remain;
   logic [8:0] div;
   logic [8:0] next_div;
   logic       active;
   logic       next_active;
   logic       tick;

   assign gi.active = active;

   // unit tick from the carrier divider or the half-bit pulse
   always_comb begin
      if (gi.unit_sel) begin
         tick = half_bit_tick; // RL2
      end else begin
         tick = (div == rcfg_pkg::UNIT_CYC - 9'h001); // RL1
      end
   end

   // count down units; a new transmit end restarts the interval
   always_comb begin
      next_state  = state;
      next_remain = remain;
      next_div    = div;
      if (tick) begin
         next_div = 9'h000;
      end else begin
         next_div = div + 9'h001;
      end
      case (state)
         rcfg_pkg::RCFG_G_IDLE: begin
            next_div = 9'h000;
         end
         rcfg_pkg::RCFG_G_RUN: begin
            if (tick) begin
               next_remain = remain - 7'h01;
               if (remain == 7'h01) begin
                  next_state = rcfg_pkg::RCFG_G_IDLE; // RL14
               end
            end
         end
         default: begin
            next_state = rcfg_pkg::RCFG_G_IDLE;
         end
      endcase
      if (gi.start) begin
         next_div    = 9'h000;
         next_remain = gi.count; // RL3
         if (gi.count == 7'h00) begin
            next_state = rcfg_pkg::RCFG_G_IDLE; // RL14
         end else begin
            next_state = rcfg_pkg::RCFG_G_RUN;
         end
      end
      next_active = (next_state == rcfg_pkg::RCFG_G_RUN);
   end

   // state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state  <= rcfg_pkg::RCFG_G_IDLE;
         remain <= 7'h00;
         div    <= 9'h000;
         active <= 1'b0;
      end else begin
         state  <= next_state;
         remain <= next_remain;
         div    <= next_div;
         active <= next_active;
      end
   end

endmodule

//--- src/rcfg_guard_if.sv
// carrier between the register bank and the guard interval timer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface rcfg_guard_if;
   logic       start;
   logic [6:0] count;
   logic       unit_sel;
   logic       active;

   modport ctrl  (output start, output count, output unit_sel,
                  input active);
   modport timer (input start, input count, input unit_sel,
                  output active);
endinterface

//--- src/rcfg_pkg.sv
// constants, register map and field layout of the receiver config bank
// assumes a 250 MHz system clock and a byte-addressed AXI4-Lite master
// Operation
// RL1: unit 0: count times 16 carrier periods
// RL2: unit 1: count times half bit period
// RL3: count bits 6-0 gate input after transmit
// RL4: bits 7-4 set decoder minimum level
// RL5: bits 3-0 set phase detector level
// RL6: bit 7 picks differential or single pin
// RL7: bit 6 picks normal or card detect
// RL8: bits 5-4 pick processing input source
// RL9: bits 1-0 collision level, 3 disables
// RL10: software writes zero to trim bits
// RL11: bits 3-2 drive high-pass corner code
// RL12: bits 1-0 drive amplifier gain code
// RL13: reserved bits read zero, ignore writes
// RL14: guard counter starts at transmit end
package rcfg_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_GUARD     = 8'h36;
   localparam logic [7:0] IDX_THRESHOLD = 8'h37;
   localparam logic [7:0] IDX_RX_CTRL   = 8'h38;
   localparam logic [7:0] IDX_ANALOG    = 8'h39;
   localparam int         ADDR_W        = 12;
   localparam int         IDX_LSB       = 2;

   // reset values of the four registers
   localparam logic [7:0] RST_GUARD     = 8'h00;
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam logic [7:0] RST_RX_CTRL   = 8'h00;
   localparam logic [7:0] RST_ANALOG    = 8'h00;

   // writable bit masks; zeros are reserved
   localparam logic [7:0] MASK_RX_CTRL  = 8'hF3;
   localparam logic [7:0] MASK_ANALOG   = 8'hCF;

   // field positions
   localparam int GUARD_UNIT_BIT = 7;
   localparam int GUARD_CNT_MSB  = 6;
   localparam int DEC_MSB        = 7;
   localparam int DEC_LSB        = 4;
   localparam int PHASE_MSB      = 3;
   localparam int SINGLE_BIT     = 7;
   localparam int CONV_BIT       = 6;
   localparam int SRC_MSB        = 5;
   localparam int SRC_LSB        = 4;
   localparam int COLL_MSB       = 1;
   localparam int TRIM_MSB       = 7;
   localparam int TRIM_LSB       = 6;
   localparam int HPCF_MSB       = 3;
   localparam int HPCF_LSB       = 2;
   localparam int GAIN_MSB       = 1;

   // collision code that switches detection off
   localparam logic [1:0] COLL_OFF = 2'h3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // guard unit 0: 16 periods of the 13.56 MHz carrier, rounded
   localparam longint CLK_HZ        = 64'd250_000_000;
   localparam longint CARRIER_HZ    = 64'd13_560_000;
   localparam longint UNIT_PERIODS  = 64'd16;
   localparam longint UNIT_CYC_L    =
      (UNIT_PERIODS * CLK_HZ + CARRIER_HZ / 2) / CARRIER_HZ;
   localparam logic [8:0] UNIT_CYC  = UNIT_CYC_L[8:0];

   typedef enum logic [1:0] {
      RCFG_G_IDLE = 2'b01,
      RCFG_G_RUN  = 2'b10
   } rcfg_guard_state_type;

   // register index from a byte address
   function automatic logic [7:0] rcfg_index(input logic [ADDR_W-1:0] a);
      rcfg_index = a[IDX_LSB+7:IDX_LSB];
   endfunction

   // true when the low address bits are word aligned
   function automatic logic rcfg_aligned(input logic [ADDR_W-1:0] a);
      rcfg_aligned = (a[IDX_LSB-1:0] == 2'h0);
   endfunction

endpackage

//--- src/rcfg_regs.sv
// receiver configuration register bank on an AXI4-Lite slave port
// assumes tx_done and half_bit_tick come from logic on aclk
// register byte address is four times the register index
`timescale 1ns/1ps
module rcfg_regs (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        tx_done,
   input  wire logic        half_bit_tick,
   output logic             rx_input_enable,
   output logic [3:0]       decoder_min_threshold,
   output logic [3:0]       phase_detector_threshold,
   output logic             single_pin_input,
   output logic             converter_mode_select,
   output logic [1:0]       processing_input_select,
   output logic [1:0]       collision_threshold,
   output logic             collision_detect_enable,
   output logic [1:0]       factory_trim_field,
   output logic [1:0]       amp_highpass_corner,
   output logic [1:0]       amp_gain
);

   rcfg_guard_if gif ();

   logic [7:0]  guard_time;
   logic [7:0]  next_guard_time;
   logic [7:0]  threshold;
   logic [7:0]  next_threshold;
   logic [7:0]  rx_ctrl;
   logic [7:0]  next_rx_ctrl;
   logic [7:0]  analog;
   logic [7:0]  next_analog;
   logic        coll_en;
   logic        next_coll_en;
   logic        aw_held;
   logic        next_aw_held;
   logic        w_held;
   logic        next_w_held;
   logic [11:0] waddr;
   logic [11:0] next_waddr;
   logic [7:0]  wbyte;
   logic [7:0]  next_wbyte;
   logic        wlane;
   logic        next_wlane;
   logic        awready;
   logic        next_awready;
   logic        wready;
   logic        next_wready;
   logic        bvalid;
   logic        next_bvalid;
   logic [1:0]  bresp;
   logic [1:0]  next_bresp;
   logic        arready;
   logic        next_arready;
   logic        rvalid;
   logic        next_rvalid;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [1:0]  rresp;
   logic [1:0]  next_rresp;
   logic        rx_en;
   logic        next_rx_en;
   logic [7:0]  widx;
   logic [7:0]  ridx;
   logic        wok;
   logic        rok;
   logic        do_write;

   // guard timer fed from the guard register
   assign gif.start    = tx_done;
   assign gif.count    = guard_time[rcfg_pkg::GUARD_CNT_MSB:0]; // RL3
   assign gif.unit_sel = guard_time[rcfg_pkg::GUARD_UNIT_BIT]; // RL1

   rcfg_guard u_guard (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .half_bit_tick (half_bit_tick),
      .gi            (gif.timer)
   );

   // bus outputs straight from flops
   assign s_axi_awready = awready;
   assign s_axi_wready  = wready;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_arready = arready;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;

   // configuration outputs are register bits; collision enable and input gate come from their own flops
   assign decoder_min_threshold =
      threshold[rcfg_pkg::DEC_MSB:rcfg_pkg::DEC_LSB]; // RL4
   assign phase_detector_threshold =
      threshold[rcfg_pkg::PHASE_MSB:0]; // RL5
   assign single_pin_input = rx_ctrl[rcfg_pkg::SINGLE_BIT]; // RL6
   assign converter_mode_select = rx_ctrl[rcfg_pkg::CONV_BIT]; // RL7
   assign processing_input_select =
      rx_ctrl[rcfg_pkg::SRC_MSB:rcfg_pkg::SRC_LSB]; // RL8
   assign collision_threshold = rx_ctrl[rcfg_pkg::COLL_MSB:0]; // RL9
   assign collision_detect_enable = coll_en;
   assign factory_trim_field =
      analog[rcfg_pkg::TRIM_MSB:rcfg_pkg::TRIM_LSB]; // RL10
   assign amp_highpass_corner =
      analog[rcfg_pkg::HPCF_MSB:rcfg_pkg::HPCF_LSB]; // RL11
   assign amp_gain = analog[rcfg_pkg::GAIN_MSB:0]; // RL12
   assign rx_input_enable = rx_en;

   // address decode for both channels
   always_comb begin
      widx = rcfg_pkg::rcfg_index(waddr);
      ridx = rcfg_pkg::rcfg_index(s_axi_araddr);
      wok  = rcfg_pkg::rcfg_aligned(waddr) &&
             (waddr[11:10] == 2'h0) &&
             ((widx == rcfg_pkg::IDX_GUARD) ||
              (widx == rcfg_pkg::IDX_THRESHOLD) ||
              (widx == rcfg_pkg::IDX_RX_CTRL) ||
              (widx == rcfg_pkg::IDX_ANALOG));
      rok  = rcfg_pkg::rcfg_aligned(s_axi_araddr) &&
             (s_axi_araddr[11:10] == 2'h0) &&
             ((ridx == rcfg_pkg::IDX_GUARD) ||
              (ridx == rcfg_pkg::IDX_THRESHOLD) ||
              (ridx == rcfg_pkg::IDX_RX_CTRL) ||
              (ridx == rcfg_pkg::IDX_ANALOG));
   end

   // write channel: address and data taken in either order
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_waddr   = waddr;
      next_wbyte   = wbyte;
      next_wlane   = wlane;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      do_write     = aw_held && w_held && !bvalid;
      if (s_axi_awvalid && awready) begin
         next_aw_held = 1'b1;
         next_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready) begin
         next_w_held = 1'b1;
         next_wbyte  = s_axi_wdata[7:0];
         next_wlane  = s_axi_wstrb[0];
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wok ? rcfg_pkg::RESP_OKAY : rcfg_pkg::RESP_SLVERR;
      end
      // no new address or data until the response is gone
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   // register contents; only byte lane 0 carries data
   always_comb begin
      next_guard_time = guard_time;
      next_threshold  = threshold;
      next_rx_ctrl    = rx_ctrl;
      next_analog     = analog;
      if (do_write && wok && wlane) begin
         case (widx)
            rcfg_pkg::IDX_GUARD: begin
               next_guard_time = wbyte;
            end
            rcfg_pkg::IDX_THRESHOLD: begin
               next_threshold = wbyte;
            end
            rcfg_pkg::IDX_RX_CTRL: begin
               next_rx_ctrl = wbyte & rcfg_pkg::MASK_RX_CTRL; // RL13
            end
            rcfg_pkg::IDX_ANALOG: begin
               next_analog = wbyte & rcfg_pkg::MASK_ANALOG; // RL13
            end
            default: begin
               next_guard_time = guard_time;
            end
         endcase
      end
      next_coll_en =
         (next_rx_ctrl[rcfg_pkg::COLL_MSB:0] != rcfg_pkg::COLL_OFF); // RL9
      // one cycle behind the timer, so a flop drives the pin
      next_rx_en = !gif.active; // RL14
   end

   // read channel: one read at a time, data one cycle after address
   always_comb begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = rok ? rcfg_pkg::RESP_OKAY : rcfg_pkg::RESP_SLVERR;
         next_rdata  = 32'h0000_0000;
         if (rok) begin
            case (ridx)
               rcfg_pkg::IDX_GUARD: begin
                  next_rdata[7:0] = guard_time;
               end
               rcfg_pkg::IDX_THRESHOLD: begin
                  next_rdata[7:0] = threshold;
               end
               rcfg_pkg::IDX_RX_CTRL: begin
                  next_rdata[7:0] = rx_ctrl;
               end
               rcfg_pkg::IDX_ANALOG: begin
                  next_rdata[7:0] = analog;
               end
               default: begin
                  next_rdata = 32'h0000_0000;
               end
            endcase
         end
      end
      next_arready = !next_rvalid;
   end

   // all state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_time <= rcfg_pkg::RST_GUARD;
         threshold  <= rcfg_pkg::RST_THRESHOLD;
         rx_ctrl    <= rcfg_pkg::RST_RX_CTRL;
         analog     <= rcfg_pkg::RST_ANALOG;
         coll_en    <= 1'b1;
         aw_held    <= 1'b0;
         w_held     <= 1'b0;
         waddr      <= 12'h000;
         wbyte      <= 8'h00;
         wlane      <= 1'b0;
         awready    <= 1'b0;
         wready     <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= 2'h0;
         arready    <= 1'b0;
         rvalid     <= 1'b0;
         rdata      <= 32'h0000_0000;
         rresp      <= 2'h0;
         rx_en      <= 1'b1;
      end else begin
         guard_time <= next_guard_time;
         threshold  <= next_threshold;
         rx_ctrl    <= next_rx_ctrl;
         analog     <= next_analog;
         coll_en    <= next_coll_en;
         aw_held    <= next_aw_held;
         w_held     <= next_w_held;
         waddr      <= next_waddr;
         wbyte      <= next_wbyte;
         wlane      <= next_wlane;
         awready    <= next_awready;
         wready     <= next_wready;
         bvalid     <= next_bvalid;
         bresp      <= next_bresp;
         arready    <= next_arready;
         rvalid     <= next_rvalid;
         rdata      <= next_rdata;
         rresp      <= next_rresp;
         rx_en      <= next_rx_en;
      end
   end

endmodule

//--- testbench/rcfg_regs_monitor.sv
// checker for the receiver config bank, watching the top ports only
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module rcfg_regs_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        tx_done,
   input wire logic        rx_input_enable,
   input wire logic [3:0]  decoder_min_threshold,
   input wire logic [3:0]  phase_detector_threshold,
   input wire logic        single_pin_input,
   input wire logic        converter_mode_select,
   input wire logic [1:0]  processing_input_select,
   input wire logic [1:0]  collision_threshold,
   input wire logic        collision_detect_enable,
   input wire logic [1:0]  factory_trim_field,
   input wire logic [1:0]  amp_highpass_corner,
   input wire logic [1:0]  amp_gain
);
   logic [11:0] rd_addr;
   logic        rd_mapped;
   logic [19:0] cfg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // address of the read in flight; its answer comes a cycle later
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr <= s_axi_araddr;
      end
   end

   // config outputs in one vector, so one check covers every field but collision enable and input gate
   assign rd_mapped = rd_addr inside {12'h0D8, 12'h0DC, 12'h0E0, 12'h0E4};
   assign cfg = {decoder_min_threshold, phase_detector_threshold,
                 single_pin_input, converter_mode_select,
                 processing_input_select, collision_threshold,
                 factory_trim_field, amp_highpass_corner, amp_gain};

   a_coll_enable: assert property (
      collision_detect_enable == (collision_threshold != 2'h3))
      else $error("collision enable does not follow its code");
   a_guard_fall: assert property (
      $fell(rx_input_enable) |-> $past(tx_done, 2))
      else $error("receive gate closed without a transmit end");
   a_cfg_on_write: assert property (
      !$stable(cfg) |-> $rose(s_axi_bvalid))
      else $error("config output moved outside a write");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped or changed while stalled");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed while stalled");
   a_reserved_zero: assert property (
      s_axi_rvalid && rd_mapped |-> s_axi_rdata[31:8] == 24'h000000
      && (rd_addr != 12'h0E0 || s_axi_rdata[3:2] == 2'h0)
      && (rd_addr != 12'h0E4 || s_axi_rdata[5:4] == 2'h0))
      else $error("reserved read bits not zero");
   a_read_resp: assert property (
      s_axi_rvalid |-> s_axi_rresp == (rd_mapped ? rcfg_pkg::RESP_OKAY
                                                  : rcfg_pkg::RESP_SLVERR))
      else $error("read response does not match the address");

   // main scenarios
   c_guard: cover property ($fell(rx_input_enable));
   c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_rd_ok: cover property (s_axi_rvalid && rd_mapped);
endmodule

//--- testbench/receiver_config_registers_tb_top.sv
// self-checking bench for the receiver config bank over AXI4-Lite
// assumes the bank answers each channel with its own ready and valid
`timescale 1ns/1ps
module receiver_config_registers_tb_top;
   logic        aclk, aresetn, tx_done, half_bit_tick;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, decoder_min_threshold, phase_detector_threshold;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, rx_input_enable;
   logic        single_pin_input, converter_mode_select;
   logic        collision_detect_enable;
   logic [1:0]  s_axi_bresp, s_axi_rresp, processing_input_select;
   logic [1:0]  collision_threshold, factory_trim_field;
   logic [1:0]  amp_highpass_corner, amp_gain;
   int          failures, compares, n;
   localparam logic [1:0] OK  = 2'h0;
   localparam logic [1:0] ERR = 2'h2;

   rcfg_regs i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tx_done, .half_bit_tick,
      .rx_input_enable, .decoder_min_threshold, .phase_detector_threshold,
      .single_pin_input, .converter_mode_select, .processing_input_select,
      .collision_threshold, .collision_detect_enable, .factory_trim_field,
      .amp_highpass_corner, .amp_gain
   );

   // 250 MHz system clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got,
                  exp);
      end
   endtask

   // both channels offered together; bready raised late to stall a cycle
   // no wait limit here: only the watchdog may end a hung transfer
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                            input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid && !s_axi_awready
                 || s_axi_wvalid && !s_axi_wready);
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
   endtask

   task automatic axi_read(input logic [11:0] a, input logic [7:0] ed,
                           input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, {24'h000000, ed}, "read data");
      check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
   endtask

   // one-cycle pulse on the transmit end or on the half-bit tick
   task automatic pulse(input bit tick);
      @(posedge aclk);
      if (tick) half_bit_tick <= 1'b1;
      else tx_done <= 1'b1;
      @(posedge aclk);
      half_bit_tick <= 1'b0;
      tx_done       <= 1'b0;
   endtask

   // watchdog: the tests need well under 3000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      complete_run();
   end

   initial begin
      aresetn = 1'b0;
      tx_done = 1'b0;
      half_bit_tick = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
      {s_axi_arvalid, s_axi_rready} = 2'b00;
      failures = 0;
      compares = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check(rx_input_enable, 1'b1, "gate after reset");
      check(collision_detect_enable, 1'b1, "coll after reset");
      for (int i = 0; i < 4; i++) begin
         axi_read(12'h0D8 + 12'(4 * i), 8'h00, OK);
      end
      // guard and threshold registers, all bits writable
      axi_write(12'h0D8, 8'h85, OK);
      axi_read(12'h0D8, 8'h85, OK);
      axi_write(12'h0DC, 8'hA5, OK);
      axi_read(12'h0DC, 8'hA5, OK);
      check(decoder_min_threshold, 4'hA, "decoder level");
      check(phase_detector_threshold, 4'h5, "phase level");
      // pin mode and converter mode, reserved bits written as ones
      axi_write(12'h0E0, 8'h80, OK);
      check({single_pin_input, converter_mode_select}, 2'b10, "modes");
      axi_write(12'h0E0, 8'h4C, OK);
      axi_read(12'h0E0, 8'h40, OK);
      check({single_pin_input, converter_mode_select}, 2'b01, "modes");
      // every source, collision, corner and gain code
      for (int i = 0; i < 4; i++) begin
         axi_write(12'h0E0, {2'b00, i[1:0], 2'b11, i[1:0]}, OK);
         axi_read(12'h0E0, {2'b00, i[1:0], 2'b00, i[1:0]}, OK);
         check(processing_input_select, i[1:0], "source");
         check(collision_threshold, i[1:0], "collision code");
         check(collision_detect_enable, i != 3, "collision on");
         axi_write(12'h0E4, {4'h3, i[1:0], ~i[1:0]}, OK);
         axi_read(12'h0E4, {4'h0, i[1:0], ~i[1:0]}, OK);
         check(factory_trim_field, 2'h0, "trim");
         check(amp_highpass_corner, i[1:0], "corner");
         check(amp_gain, {30'h0, ~i[1:0]}, "gain");
      end
      // strobe on byte 0 clear: answered but nothing stored
      s_axi_wstrb <= 4'hE;
      axi_write(12'h0DC, 8'h11, OK);
      s_axi_wstrb <= 4'hF;
      axi_read(12'h0DC, 8'hA5, OK);
      // unmapped, misaligned and out-of-range addresses
      axi_write(12'h0E8, 8'h55, ERR);
      axi_read(12'h0E8, 8'h00, ERR);
      axi_read(12'h0D9, 8'h00, ERR);
      axi_write(12'h4D8, 8'hFF, ERR);
      axi_read(12'h0D8, 8'h85, OK);
      // zero count: the gate never closes
      axi_write(12'h0D8, 8'h00, OK);
      pulse(1'b0);
      n = 0;
      repeat (6) begin
         @(posedge aclk);
         if (rx_input_enable !== 1'b1) n++;
      end
      check(n, 0, "gate with zero count");
      // carrier unit: two units of 16 carrier periods each
      axi_write(12'h0D8, 8'h02, OK);
      pulse(1'b0);
      n = 0;
      for (int k = 0; k < 1000; k++) begin
         @(posedge aclk);
         if (rx_input_enable === 1'b0) n++;
         else if (n > 0) break;
      end
      check(n, 32'(rcfg_pkg::UNIT_CYC) * 2, "carrier guard span");
      // half-bit unit: the third tick opens the gate
      axi_write(12'h0D8, 8'h83, OK);
      pulse(1'b0);
      repeat (4) @(posedge aclk);
      check(rx_input_enable, 1'b0, "gate closed");
      repeat (2) begin
         repeat (5) @(posedge aclk);
         pulse(1'b1);
      end
      repeat (5) @(posedge aclk);
      check(rx_input_enable, 1'b0, "gate after two ticks");
      pulse(1'b1);
      repeat (2) @(posedge aclk);
      check(rx_input_enable, 1'b1, "gate after third tick");
      complete_run();
   end
endmodule

bind rcfg_regs rcfg_regs_monitor i_mon (
   .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .tx_done, .rx_input_enable,
   .decoder_min_threshold, .phase_detector_threshold, .single_pin_input,
   .converter_mode_select, .processing_input_select, .collision_threshold,
   .collision_detect_enable, .factory_trim_field, .amp_highpass_corner,
   .amp_gain
);
